// ---- hdl/spc_pkg.sv ----
package spc_pkg;
   localparam int NUM_UNITS = 32;
   localparam int IDX_W     = 7;
   // word indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_SYNERR    = 7'h02;
   localparam logic [IDX_W-1:0] IDX_PERMIT0   = 7'h03;
   localparam logic [IDX_W-1:0] IDX_PERMIT3   = 7'h06;
   localparam logic [IDX_W-1:0] IDX_TYPE0     = 7'h07;
   localparam logic [IDX_W-1:0] TYPE_STRIDE   = 7'h03;
   localparam logic [IDX_W-1:0] IDX_IRQ_STAT  = 7'h68;
   localparam logic [IDX_W-1:0] IDX_IRQ_MASK  = 7'h69;
   localparam logic [IDX_W-1:0] IDX_CTRL      = 7'h6A;
   localparam logic [IDX_W-1:0] IDX_POLL_STAT = 7'h6B;
   // protocol field codes
   localparam logic [7:0] PROTO_NONE   = 8'h00;
   localparam logic [7:0] PROTO_LEGACY = 8'h01;
   localparam logic [7:0] PROTO_STRUCT = 8'h02;
   localparam logic [3:0] GROUP_MIN    = 4'h1;
   localparam logic [3:0] GROUP_MAX    = 4'h5;
   localparam logic [3:0] SEG_TEMP     = 4'h1;
   localparam logic [3:0] SEG_METER    = 4'h2;
   // interrupt status bits
   localparam int IRQ_SYNTAX  = 0;
   localparam int IRQ_FATAL   = 1;
   localparam int IRQ_RD_FAIL = 2;
   localparam int IRQ_WR_FAIL = 3;
   localparam int IRQ_PASS    = 4;
   localparam int IRQ_W       = 5;
   // control bits
   localparam int CTRL_RUN    = 0;
   localparam int CTRL_CLRSYN = 1;
   localparam logic [15:0] RST_WORD  = 16'h0000;
   localparam logic [15:0] RST_CTRL  = 16'h0000;

   typedef struct packed {
      logic [3:0] segment;
      logic [3:0] group;
      logic [7:0] proto;
   } spc_type_word_t;

   typedef struct packed {
      logic [4:0] unit;
      logic       write;
      logic [7:0] proto;
      logic [3:0] group;
      logic [3:0] segment;
   } spc_cmd_t;

   typedef struct packed {
      logic [4:0] unit;
      logic       write;
      logic [7:0] code;
   } spc_mon_t;
endpackage : spc_pkg

// ---- hdl/spc_config_bank.sv ----
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module spc_config_bank #(
   parameter logic [15:0] DM_BASE = 16'h0000
) (
   input  wire logic                clk,
   input  wire logic                reset,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [11:0]         paddr,
   input  wire logic [31:0]         pwdata,
   input  wire logic [3:0]          pstrb,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   output spc_pkg::spc_cmd_t        cmd,
   output logic                     cmd_valid,
   input  wire logic                cmd_done,
   input  wire logic                cmd_fail,
   input  wire logic [7:0]          cmd_code,
   output spc_pkg::spc_mon_t        mon,
   output logic                     mon_valid,
   input  wire logic                host_write_fault,
   input  wire logic                host_link_lost,
   output logic                     err_led,
   output logic                     irq
);
   import spc_pkg::*;

   typedef enum logic [2:0] {
      spc_idle, spc_chk_rd, spc_wait_rd, spc_chk_wr, spc_wait_wr
   } spc_state_t;

   logic [15:0]             permit [4];
   spc_type_word_t          type_word [NUM_UNITS];
   logic [15:0]             synerr_addr;
   logic                    synerr_valid;
   logic [15:0]             ctrl;
   logic [IRQ_W-1:0]        irq_stat;
   logic [IRQ_W-1:0]        irq_mask;
   logic                    fatal;
   spc_state_t              state;
   logic [4:0]              cur;
   logic [4:0]              last_done;

   logic                    acc;
   logic                    wr_acc;
   logic                    rd_acc;
   logic [IDX_W-1:0]        idx;
   logic                    hit_type;
   logic [4:0]              type_unit;
   logic                    hit_permit;
   logic                    mapped;
   logic [15:0]             old_word;
   logic [15:0]             new_word;
   logic [31:0]             next_rdata;
   logic                    syn_event;
   logic [IRQ_W-1:0]        events;
   spc_type_word_t          cur_type;
   logic                    cur_known;
   logic                    cur_rd_ok;
   logic                    cur_wr_ok;
   logic                    halt;

   // access phase completes at the edge where pready is high
   assign acc    = psel && penable && pready;
   assign wr_acc = acc && pwrite;
   assign rd_acc = acc && !pwrite;
   assign idx    = paddr[IDX_W+1:2];

   function automatic logic permit_bit(input logic [15:0] w [4],
                                       input logic [4:0] u, input logic wr);
      logic [3:0] pos;
      pos = {~u[2:0], wr};
      return w[u[4:3]][pos];
   endfunction : permit_bit

   function automatic logic proto_known(input logic [7:0] p);
      return p == PROTO_NONE || p == PROTO_LEGACY || p == PROTO_STRUCT;
   endfunction : proto_known

   // address decode
   always_comb begin
      hit_type  = 1'b0;
      type_unit = 5'd0;
      for (int u = 0; u < NUM_UNITS; u++) begin
         if (idx == IDX_TYPE0 + TYPE_STRIDE * IDX_W'(u)) begin
            hit_type  = 1'b1;
            type_unit = 5'(u);
         end
      end
   end

   assign hit_permit = idx >= IDX_PERMIT0 && idx <= IDX_PERMIT3;
   assign mapped = hit_type || hit_permit || idx == IDX_SYNERR ||
                   idx == IDX_IRQ_STAT || idx == IDX_IRQ_MASK ||
                   idx == IDX_CTRL || idx == IDX_POLL_STAT;

   always_comb begin
      if (hit_type) begin
         old_word = type_word[type_unit];
      end else if (hit_permit) begin
         old_word = permit[2'(idx - IDX_PERMIT0)];
      end else if (idx == IDX_SYNERR) begin
         old_word = synerr_addr;
      end else if (idx == IDX_IRQ_STAT) begin
         old_word = 16'(irq_stat);
      end else if (idx == IDX_IRQ_MASK) begin
         old_word = 16'(irq_mask);
      end else if (idx == IDX_CTRL) begin
         old_word = ctrl;
      end else if (idx == IDX_POLL_STAT) begin
         old_word = {fatal, synerr_valid, 1'b0, ctrl[CTRL_RUN] && !fatal,
                     1'b0, 3'(state), 3'h0, last_done};
      end else begin
         old_word = RST_WORD;
      end
   end

   assign new_word = {pstrb[1] ? pwdata[15:8] : old_word[15:8],
                      pstrb[0] ? pwdata[7:0]  : old_word[7:0]};
   assign next_rdata = {16'h0000, old_word};

   // apb answer: one wait cycle, then pready for one cycle
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !mapped;
         if (psel && penable && !pready) begin
            prdata <= pwrite ? 32'h0000_0000 : next_rdata;
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         for (int w = 0; w < 4; w++) begin
            permit[w] <= RST_WORD;
         end
      end else if (wr_acc && hit_permit) begin
         permit[2'(idx - IDX_PERMIT0)] <= new_word;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         for (int u = 0; u < NUM_UNITS; u++) begin
            type_word[u] <= RST_WORD;
         end
      end else if (wr_acc && hit_type) begin
         type_word[type_unit] <= new_word;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ctrl     <= RST_CTRL;
         irq_mask <= '0;
      end else if (wr_acc && idx == IDX_CTRL) begin
         ctrl <= new_word & 16'h0001;
      end else if (wr_acc && idx == IDX_IRQ_MASK) begin
         irq_mask <= new_word[IRQ_W-1:0];
      end
   end

   // syntax error: unknown protocol written to a type word
   assign syn_event = wr_acc && hit_type &&
                      !proto_known(new_word[7:0]);

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         synerr_valid <= 1'b0;
         synerr_addr  <= RST_WORD;
      end else if (syn_event && (!synerr_valid ||
                   (wr_acc && idx == IDX_CTRL && new_word[CTRL_CLRSYN]))) begin
         synerr_valid <= 1'b1;
         synerr_addr  <= DM_BASE + 16'(idx);
      end else if (wr_acc && idx == IDX_CTRL && new_word[CTRL_CLRSYN]) begin
         synerr_valid <= 1'b0;
         synerr_addr  <= RST_WORD;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         fatal   <= 1'b0;
         err_led <= 1'b0;
      end else if (host_write_fault || host_link_lost) begin
         fatal   <= 1'b1;
         err_led <= 1'b1;
      end
   end

   // decode of the unit under poll
   assign cur_type  = type_word[cur];
   assign cur_known = cur_type.proto == PROTO_LEGACY ||
                      cur_type.proto == PROTO_STRUCT;
   assign cur_rd_ok = cur_known && permit_bit(permit, cur, 1'b0);
   assign cur_wr_ok = cur_known && permit_bit(permit, cur, 1'b1);
   assign halt      = fatal || !ctrl[CTRL_RUN];

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state     <= spc_idle;
         cur       <= 5'd0;
         last_done <= 5'd0;
         cmd_valid <= 1'b0;
         cmd       <= '0;
      end else if (fatal) begin
         state     <= spc_idle;
         cmd_valid <= 1'b0;
      end else begin
         case (state)
            spc_idle: begin
               if (!halt) begin
                  state <= spc_chk_rd;
               end
            end
            spc_chk_rd: begin
               if (halt) begin
                  state <= spc_idle;
               end else if (cur_rd_ok) begin
                  state          <= spc_wait_rd;
                  cmd_valid      <= 1'b1;
                  cmd.unit       <= cur;
                  cmd.write      <= 1'b0;
                  cmd.proto      <= cur_type.proto;
                  cmd.group      <= (cur_type.proto == PROTO_LEGACY &&
                                     cur_type.group >= GROUP_MIN &&
                                     cur_type.group <= GROUP_MAX) ?
                                    cur_type.group : 4'h0;
                  cmd.segment    <= (cur_type.proto == PROTO_LEGACY &&
                                     (cur_type.segment == SEG_TEMP ||
                                      cur_type.segment == SEG_METER)) ?
                                    cur_type.segment : 4'h0;
               end else begin
                  state <= spc_chk_wr;
               end
            end
            spc_wait_rd: begin
               if (cmd_done) begin
                  cmd_valid <= 1'b0;
                  last_done <= cur;
                  state     <= spc_chk_wr;
               end
            end
            spc_chk_wr: begin
               if (cur_wr_ok && !halt) begin
                  state          <= spc_wait_wr;
                  cmd_valid      <= 1'b1;
                  cmd.unit       <= cur;
                  cmd.write      <= 1'b1;
                  cmd.proto      <= cur_type.proto;
                  cmd.group      <= (cur_type.proto == PROTO_LEGACY &&
                                     cur_type.group >= GROUP_MIN &&
                                     cur_type.group <= GROUP_MAX) ?
                                    cur_type.group : 4'h0;
                  cmd.segment    <= (cur_type.proto == PROTO_LEGACY &&
                                     (cur_type.segment == SEG_TEMP ||
                                      cur_type.segment == SEG_METER)) ?
                                    cur_type.segment : 4'h0;
               end else begin
                  cur   <= cur + 5'd1;
                  state <= halt ? spc_idle : spc_chk_rd;
               end
            end
            spc_wait_wr: begin
               if (cmd_done) begin
                  cmd_valid <= 1'b0;
                  cur       <= cur + 5'd1;
                  state     <= spc_chk_rd;
               end
            end
            default: state <= spc_idle;
         endcase
      end
   end
   // response monitor report of a failed transfer
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         mon_valid <= 1'b0;
         mon       <= '0;
      end else begin
         mon_valid <= cmd_valid && cmd_done && cmd_fail;
         if (cmd_valid && cmd_done && cmd_fail) begin
            mon.unit  <= cmd.unit;
            mon.write <= cmd.write;
            mon.code  <= cmd_code;
         end
      end
   end
   assign events[IRQ_SYNTAX]  = syn_event;
   assign events[IRQ_FATAL]   = (host_write_fault || host_link_lost) && !fatal;
   assign events[IRQ_RD_FAIL] = cmd_valid && cmd_done && cmd_fail && !cmd.write;
   assign events[IRQ_WR_FAIL] = cmd_valid && cmd_done && cmd_fail && cmd.write;
   assign events[IRQ_PASS]    = state == spc_chk_wr && cur == 5'd31 &&
                                !(cur_wr_ok && !halt) && !fatal;
   // read clears only the bits that it reported; a new event wins
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         irq_stat <= '0;
         irq      <= 1'b0;
      end else begin
         irq_stat <= (irq_stat & ~(rd_acc && idx == IDX_IRQ_STAT ?
                      prdata[IRQ_W-1:0] : '0)) | events;
         irq      <= |(((irq_stat & ~(rd_acc && idx == IDX_IRQ_STAT ?
                      prdata[IRQ_W-1:0] : '0)) | events) & irq_mask);
      end
   end
   chk_read_permit: assert property (@(posedge clk) disable iff (reset)
      $rose(cmd_valid) && !cmd.write |-> cmd.unit == $past(cur) &&
         $past(permit_bit(permit, cur, 1'b0)))
      else $error("read issued without read permission");
   chk_write_permit: assert property (@(posedge clk) disable iff (reset)
      $rose(cmd_valid) && cmd.write |-> cmd.unit == $past(cur) &&
         $past(permit_bit(permit, cur, 1'b1)))
      else $error("write issued without write permission");
   chk_skip_absent: assert property (@(posedge clk) disable iff (reset)
      cmd_valid |-> cmd.proto == PROTO_LEGACY || cmd.proto == PROTO_STRUCT)
      else $error("command to absent or invalid unit");
   chk_group_gate: assert property (@(posedge clk) disable iff (reset)
      cmd_valid && cmd.group != 4'h0 |->
         cmd.proto == PROTO_LEGACY && cmd.group >= GROUP_MIN && cmd.group <= GROUP_MAX)
      else $error("command group passed when invalid");
   chk_segment_gate: assert property (@(posedge clk) disable iff (reset)
      cmd_valid && cmd.segment != 4'h0 |->
         cmd.proto == PROTO_LEGACY && (cmd.segment == SEG_TEMP || cmd.segment == SEG_METER))
      else $error("segment passed when invalid");
   chk_monitor_report: assert property (@(posedge clk) disable iff (reset)
      cmd_valid && cmd_done && cmd_fail |=>
         mon_valid && mon.write == $past(cmd.write) && mon.code == $past(cmd_code))
      else $error("failed transfer not reported");
   chk_syntax_first: assert property (@(posedge clk) disable iff (reset)
      synerr_valid && !(wr_acc && idx == IDX_CTRL) |=> $stable(synerr_addr))
      else $error("syntax address overwritten");
   chk_syntax_addr: assert property (@(posedge clk) disable iff (reset)
      syn_event && !synerr_valid |=> synerr_valid && synerr_addr == DM_BASE + 16'($past(idx)))
      else $error("syntax address not recorded");
   chk_fatal_halt: assert property (@(posedge clk) disable iff (reset)
      host_write_fault || host_link_lost |=> ##1 !cmd_valid && err_led && state == spc_idle)
      else $error("traffic not halted after fatal");
endmodule : spc_config_bank
`default_nettype wire

// ---- verification/spc_link_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module spc_link_model (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire spc_pkg::spc_cmd_t cmd,
   input  wire logic        cmd_valid,
   input  wire logic        fail_en,
   output logic             cmd_done,
   output logic             cmd_fail,
   output logic [7:0]       cmd_code
);
   import spc_pkg::*;
   logic       busy;
   logic       slow;
   logic [1:0] cnt;

   // answers alternately at once and after three idle cycles
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         busy     <= 1'b0;
         slow     <= 1'b0;
         cnt      <= 2'h0;
         cmd_done <= 1'b0;
         cmd_fail <= 1'b0;
         cmd_code <= 8'h00;
      end else begin
         cmd_done <= 1'b0;
         cmd_fail <= ~cmd_fail;
         cmd_code <= ~cmd_code;
         if (cmd_valid && !busy && !cmd_done) begin
            busy <= 1'b1;
            cnt  <= slow ? 2'h3 : 2'h0;
            slow <= ~slow;
         end else if (busy && cnt != 2'h0) begin
            cnt <= cnt - 2'h1;
         end else if (busy) begin
            busy     <= 1'b0;
            cmd_done <= 1'b1;
            // first and last unit fail when asked, code tells unit and direction
            cmd_fail <= fail_en && (cmd.unit == 5'h00 || cmd.unit == 5'h1F);
            cmd_code <= {cmd.write, 2'h0, cmd.unit};
         end
      end
   end
endmodule : spc_link_model
`default_nettype wire

// ---- verification/test_serial_poll_config_words.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_serial_poll_config_words;
   import spc_pkg::*;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0]  pstrb = 4'hF;
   logic [31:0] prdata;
   logic        pready, pslverr, cmd_valid, cmd_done, cmd_fail, mon_valid;
   logic [7:0]  cmd_code;
   spc_cmd_t    cmd;
   spc_mon_t    mon;
   logic        host_write_fault = 1'b0, host_link_lost = 1'b0, fail_en = 1'b0;
   logic        err_led, irq, cv_q = 1'b0, err;
   logic [31:0] rd;
   spc_cmd_t    cmd_log[$];
   spc_mon_t    mon_log[$];
   int          n_errors = 0, comparisons = 0, n, snap;

   always #5 clk = ~clk;

   spc_config_bank u_spc_config_bank (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cmd(cmd), .cmd_valid(cmd_valid),
      .cmd_done(cmd_done), .cmd_fail(cmd_fail), .cmd_code(cmd_code), .mon(mon),
      .mon_valid(mon_valid), .host_write_fault(host_write_fault),
      .host_link_lost(host_link_lost), .err_led(err_led), .irq(irq));

   spc_link_model u_spc_link_model (.clk(clk), .reset(reset), .cmd(cmd), .cmd_valid(cmd_valid),
      .fail_en(fail_en), .cmd_done(cmd_done), .cmd_fail(cmd_fail), .cmd_code(cmd_code));

   // logs every issued command and every monitor store
   always @(posedge clk) begin
      if (cmd_valid === 1'b1 && !cv_q) cmd_log.push_back(cmd);
      cv_q <= (cmd_valid === 1'b1);
      if (mon_valid === 1'b1) mon_log.push_back(mon);
   end

   task automatic finish_test();
      $display("counts: comparisons=%0d errors=%0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : finish_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic timeout_hit();
      n_errors++;
      $display("ERROR at %0t: wait ran out, got %h expected %h", $time, 1'b0, 1'b1);
      finish_test();
   endtask : timeout_hit

   task automatic apb(input logic wr, input logic [6:0] idx, input logic [15:0] wd);
      int k;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {3'h0, idx, 2'h0};
      pwdata  <= {16'h0000, wd};
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) timeout_hit();
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   function automatic spc_cmd_t mk(logic [4:0] u, logic w, logic [7:0] p, logic [3:0] g,
                                   logic [3:0] s);
      mk = {u, w, p, g, s};
   endfunction : mk

   function automatic int writes_to(logic [4:0] u);
      writes_to = 0;
      foreach (cmd_log[i]) if (cmd_log[i].unit == u && cmd_log[i].write) writes_to++;
   endfunction : writes_to

   initial begin
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      apb(1'b0, IDX_PERMIT0, 16'h0); chk(rd, {16'h0, RST_WORD});
      apb(1'b0, IDX_TYPE0, 16'h0); chk(rd, {16'h0, RST_WORD});
      apb(1'b0, 7'h08, 16'h0); chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      $display("test reset_and_map done");

      apb(1'b1, IDX_IRQ_MASK, 16'h0000);
      apb(1'b1, IDX_PERMIT0, 16'h4010);
      apb(1'b1, IDX_PERMIT3, 16'h0003);
      apb(1'b1, IDX_TYPE0, 16'h1301);
      apb(1'b1, 7'h64, 16'h1302);
      apb(1'b1, 7'h16, 16'h0007);
      apb(1'b1, 7'h19, 16'h0009);
      chk({31'h0, irq}, 32'h0);
      apb(1'b0, IDX_SYNERR, 16'h0); chk(rd, 32'h0016);
      apb(1'b1, IDX_SYNERR, 16'hFFFF);
      apb(1'b0, IDX_SYNERR, 16'h0); chk(rd, 32'h0016);
      apb(1'b0, 7'h64, 16'h0); chk(rd, 32'h1302);
      apb(1'b1, IDX_CTRL, 16'h0002);
      apb(1'b0, IDX_SYNERR, 16'h0); chk(rd, 32'h0000);
      apb(1'b1, 7'h19, 16'h0009);
      apb(1'b0, IDX_SYNERR, 16'h0); chk(rd, 32'h0019);
      apb(1'b1, IDX_IRQ_MASK, 16'h0001);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      apb(1'b0, IDX_IRQ_STAT, 16'h0); chk(rd, 32'h1);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      apb(1'b0, IDX_IRQ_STAT, 16'h0); chk(rd, 32'h0);
      $display("test config_and_syntax done");

      fail_en <= 1'b1;
      apb(1'b1, IDX_CTRL, 16'h0001);
      for (n = 0; n < 3000 && mon_log.size() < 3; n++) @(posedge clk);
      if (n >= 3000) timeout_hit();
      chk({10'h0, cmd_log[0]}, {10'h0, mk(5'h00, 1'b0, PROTO_LEGACY, 4'h3, SEG_TEMP)});
      chk({10'h0, cmd_log[1]}, {10'h0, mk(5'h1F, 1'b0, PROTO_STRUCT, 4'h0, 4'h0)});
      chk({10'h0, cmd_log[2]}, {10'h0, mk(5'h1F, 1'b1, PROTO_STRUCT, 4'h0, 4'h0)});
      chk({18'h0, mon_log[0]}, {18'h0, 5'h00, 1'b0, 8'h00});
      chk({18'h0, mon_log[1]}, {18'h0, 5'h1F, 1'b0, 8'h1F});
      chk({18'h0, mon_log[2]}, {18'h0, 5'h1F, 1'b1, 8'h9F});
      apb(1'b1, IDX_PERMIT3, 16'h0001);
      repeat (3) @(posedge clk);
      snap = writes_to(5'h1F);
      repeat (300) @(posedge clk);
      chk(32'(writes_to(5'h1F)), 32'(snap));
      chk(32'(writes_to(5'h00)), 32'h0);
      foreach (cmd_log[i])
         if (cmd_log[i].unit != 5'h00 && cmd_log[i].unit != 5'h1F)
            chk({27'h0, cmd_log[i].unit}, 32'h0);
      $display("test polling done");

      host_link_lost <= 1'b1;
      repeat (3) @(posedge clk);
      chk({31'h0, err_led}, 32'h1);
      chk({31'h0, cmd_valid}, 32'h0);
      snap = cmd_log.size();
      host_link_lost <= 1'b0;
      repeat (100) @(posedge clk);
      chk(32'(cmd_log.size()), 32'(snap));
      chk({31'h0, err_led}, 32'h1);
      apb(1'b0, IDX_IRQ_STAT, 16'h0); chk(rd, 32'h0000_001E);
      apb(1'b0, IDX_POLL_STAT, 16'h0); chk(rd & 32'h0000_FF00, 32'h0000_C000);
      $display("test fatal_halt done");
      finish_test();
   end
endmodule : test_serial_poll_config_words
`default_nettype wire
